// ### rtl/icw_words.sv
/*
  Builds the feature, DMA mode, power and advanced timing identification
  words and serves them, along with their settings, over an APB slave.
  Assumes an APB master on clk_sys_i, and that the health monitoring enable
  bit is written back to non volatile storage by logic outside this block
  whenever nv_store_o pulses, and reloaded through nv_health_i at reset.
*/
// Our own choices: the APB register port and the placing of the registers.
// Overview of operation
// - Supported words carry bit14 one, bit15 zero.
// - First supported word fixed bits set and cleared.
// - Health, security, cache, look-ahead support configurable.
// - Second supported word shows flash-card set.
// - Third enabled word tagged valid, rest reserved.
// - Health enable host-changed and kept non-volatile.
// - Security, cache, look-ahead enables reported live.
// - First enabled word mirrors fixed support bits.
// - Power management enable bit after set-features.
// - At most one DMA mode selected.
// - Ultra DMA word zero outside disk emulation.
// - Ultra DMA selection one-hot in bits 8-14.
// - Ultra DMA support bits are cumulative.
// - Power word valid, reserved, absent, disabled flags.
// - Power word low bits give max current.
// - Advanced timing bits 2-0 give PIO support.
// - Advanced timing bits 5-3 give DMA support.
// - Advanced timing reports selected PIO, DMA modes.
// - Card-bus bits 2-0 give I/O cycle mode.
// - Card-bus bits 5-3 give memory cycle mode.
// - Card-bus ultra DMA limits valid with bit15.
// - Card-bus bits 14-12 report selected ultra DMA.
// - Translation word bit 2 marks ultra word valid.
`timescale 1ns/1ps
`default_nettype none

module icw_words (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        nv_health_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic      [15:0] ident_word_o,
  output logic             nv_store_o
);
  import icw_pkg::*;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Out of range codes collapse to the reserved code so the host never sees
  // a mode claimed that the card cannot run.
  function automatic logic [2:0] clip(input logic [2:0] v,
                                      input logic [2:0] lim);
    clip = (v > lim) ? `ICW_CODE_RSV : v;
  endfunction

  function automatic logic [6:0] cumul(input logic [2:0] n);
    cumul = 7'h7F >> (3'h6 - clip(n, `ICW_ULTRA_DMA_MAX));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  icw_state_t st_reg;
  icw_state_t st_next;
  logic       hs_meta_reg;
  logic       hs_sync_reg;
  logic       boot_reg;

  logic [15:0] sup0_w;
  logic [15:0] sup1_w;
  logic [15:0] sup2_w;
  logic [15:0] en0_w;
  logic [15:0] en1_w;
  logic [15:0] en2_w;
  logic [15:0] ultra_dma_w;
  logic [15:0] pwr_w;
  logic [15:0] adv_w;
  logic [15:0] cbus_w;
  logic [15:0] sel_w;
  logic [31:0] cfg_v;
  logic [31:0] mode_v;
  logic [31:0] feat_v;
  logic [31:0] tim_v;
  logic [31:0] rd_v;
  logic [31:0] wr_v;
  logic        access;
  logic        hit;

  // -------------------------------------------------------------------------
  // Word assembly
  // -------------------------------------------------------------------------
  always_comb begin
    sup0_w = `ICW_FEAT0_FIXED;
    sup0_w[0] = st_reg.sup_cfg[0];
    sup0_w[1] = st_reg.sup_cfg[1];
    sup0_w[5] = st_reg.sup_cfg[2];
    sup0_w[6] = st_reg.sup_cfg[3];
    sup1_w = `ICW_FEAT1_FLASH;
    sup1_w[3] = st_reg.sup_cfg[4];
    sup2_w = `ICW_VALID_TAG;
    en0_w = `ICW_FEAT0_FIXED;
    en0_w[0] = st_reg.feat_en[0];
    en0_w[1] = st_reg.feat_en[1];
    en0_w[5] = st_reg.feat_en[2];
    en0_w[6] = st_reg.feat_en[3];
    en1_w = 16'h0004;
    en1_w[3] = st_reg.feat_en[4];
    en2_w = `ICW_VALID_TAG;
    ultra_dma_w = 16'h0000;
    if (st_reg.disk_emulation_mode &&
        (st_reg.ultra_dma_sup != `ICW_CODE_RSV)) begin
      ultra_dma_w[6:0] = cumul(st_reg.ultra_dma_sup);
      if (st_reg.dma_kind == ICW_DMA_ULTRA) begin
        ultra_dma_w[14:8] = 7'h01 << st_reg.ultra_dma_sel;
      end
    end
    pwr_w = {st_reg.pwr_cfg[15], 1'b0,
             st_reg.pwr_cfg[13:12],
             st_reg.pwr_cfg[11:0]};
    adv_w = {4'h0,
             (st_reg.dma_kind == ICW_DMA_MWORD) ?
               st_reg.adv_mdma_sel : 3'h0,
             st_reg.adv_pio_sel,
             clip(st_reg.timing_cap[5:3], `ICW_ADV_MAX),
             clip(st_reg.timing_cap[2:0], `ICW_ADV_MAX)};
    cbus_w = {st_reg.timing_cap[17],
              st_reg.cb_ultra_dma_sel,
              clip(st_reg.timing_cap[11:9], `ICW_ULTRA_DMA_MAX),
              clip(st_reg.timing_cap[14:12], `ICW_ULTRA_DMA_MAX),
              clip(st_reg.timing_cap[8:6], `ICW_CB_MAX),
              clip(st_reg.timing_cap[2:0], `ICW_CB_MAX)};
    unique case (st_reg.word_index)
      `ICW_W_XLAT: sel_w = `ICW_XLAT_VALUE;
      `ICW_W_SUP0: sel_w = sup0_w;
      `ICW_W_SUP1: sel_w = sup1_w;
      `ICW_W_SUP2: sel_w = sup2_w;
      `ICW_W_EN0:  sel_w = en0_w;
      `ICW_W_EN1:  sel_w = en1_w;
      `ICW_W_EN2:  sel_w = en2_w;
      `ICW_W_ULTRA_DMA: sel_w = ultra_dma_w;
      `ICW_W_PWR:  sel_w = pwr_w;
      `ICW_W_ADV:  sel_w = adv_w;
      `ICW_W_CBUS: sel_w = cbus_w;
      default:     sel_w = 16'h0000;
    endcase
  end

  // -------------------------------------------------------------------------
  // Register views
  // -------------------------------------------------------------------------
  always_comb begin
    cfg_v  = {st_reg.pwr_cfg, 3'h0, st_reg.disk_emulation_mode,
              st_reg.ultra_dma_sup, 1'b0, st_reg.sup_cfg};
    mode_v = {16'h0000, 1'b0, st_reg.cb_ultra_dma_sel,
              st_reg.adv_mdma_sel, st_reg.adv_pio_sel,
              st_reg.ultra_dma_sel, 1'b0, st_reg.dma_kind};
    feat_v = {27'h0, st_reg.feat_en};
    tim_v  = {14'h0, st_reg.timing_cap};
    access = psel_i && penable_i && !st_reg.pready;
    hit    = 1'b1;
    wr_v   = 32'h0;
    unique case (paddr_i)
      `ICW_ADDR_CFG:    rd_v = cfg_v;
      `ICW_ADDR_MODE:   rd_v = mode_v;
      `ICW_ADDR_FEAT:   rd_v = feat_v;
      `ICW_ADDR_TIMING: rd_v = tim_v;
      `ICW_ADDR_INDEX:  rd_v = {24'h0, st_reg.word_index};
      `ICW_ADDR_DATA:   rd_v = {16'h0, st_reg.word_data};
      `ICW_ADDR_STATUS: rd_v = {29'h0, boot_reg, st_reg.dma_kind};
      default: begin
        rd_v = 32'h0;
        hit  = 1'b0;
      end
    endcase
    wr_v = merge(rd_v, pwdata_i, pstrb_i);
  end

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.pready   = access;
    st_next.pslverr  = access && !hit;
    st_next.nv_store = 1'b0;
    st_next.word_data = sel_w;
    if (access && !pwrite_i) begin
      st_next.prdata = rd_v;
    end
    if (!boot_reg) begin
      st_next.feat_en[0] = hs_sync_reg;
    end
    if (access && pwrite_i && hit) begin
      unique case (paddr_i)
        `ICW_ADDR_CFG: begin
          st_next.sup_cfg  = wr_v[7:0];
          st_next.ultra_dma_sup = wr_v[11:9];
          st_next.disk_emulation_mode = wr_v[12];
          st_next.pwr_cfg  = wr_v[31:16];
        end
        `ICW_ADDR_MODE: begin
          // An illegal both-kinds request sets the DMA kind to none; the selection fields are still stored.
          st_next.dma_kind = (wr_v[1:0] == 2'b11) ?
                             ICW_DMA_NONE : icw_dma_kind_t'(wr_v[1:0]);
          st_next.ultra_dma_sel     = clip(wr_v[5:3], `ICW_ULTRA_DMA_MAX);
          st_next.adv_pio_sel  = clip(wr_v[8:6], `ICW_ADV_MAX);
          st_next.adv_mdma_sel = clip(wr_v[11:9], `ICW_ADV_MAX);
          st_next.cb_ultra_dma_sel  = clip(wr_v[14:12], `ICW_ULTRA_DMA_MAX);
        end
        `ICW_ADDR_FEAT: begin
          st_next.feat_en = wr_v[4:0];
          st_next.nv_store = (wr_v[0] != st_reg.feat_en[0]);
        end
        `ICW_ADDR_TIMING: st_next.timing_cap = wr_v[17:0];
        `ICW_ADDR_INDEX:  st_next.word_index = wr_v[7:0];
        default: st_next.word_index = st_reg.word_index;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    hs_meta_reg <= nv_health_i;
    hs_sync_reg <= hs_meta_reg;
    if (!rstn_i) begin
      boot_reg <= 1'b0;
      st_reg <= '{pwr_cfg: {4'h8, `ICW_CUR_RST},
                  dma_kind: ICW_DMA_NONE,
                  default: '0};
    end else begin
      // Boot ends once both synchroniser stages agree and no APB answer is pending.
      boot_reg <= boot_reg |
                  (st_reg.pready == 1'b0 && hs_meta_reg == hs_sync_reg);
      st_reg <= st_next;
    end
  end

  assign prdata_o     = st_reg.prdata;
  assign pready_o     = st_reg.pready;
  assign pslverr_o    = st_reg.pslverr;
  assign ident_word_o = st_reg.word_data;
  assign nv_store_o   = st_reg.nv_store;

endmodule // icw_words

`default_nettype wire

// ### rtl/icw_params.svh
/*
  Holds the offsets, word indices, reset values and fixed codes of the
  identify capability word block and its APB register map.
  Assumes inclusion by bare name from the package only.
*/
`ifndef ICW_PARAMS_SVH
`define ICW_PARAMS_SVH

// ---------------------------------------------------------------------------
// APB register byte addresses
// ---------------------------------------------------------------------------
`define ICW_ADDR_CFG      12'h000
`define ICW_ADDR_MODE     12'h004
`define ICW_ADDR_FEAT     12'h008
`define ICW_ADDR_TIMING   12'h00C
`define ICW_ADDR_INDEX    12'h010
`define ICW_ADDR_DATA     12'h014
`define ICW_ADDR_STATUS   12'h018

// ---------------------------------------------------------------------------
// Identification word indices
// ---------------------------------------------------------------------------
`define ICW_W_XLAT        8'h35
`define ICW_W_SUP0        8'h52
`define ICW_W_SUP1        8'h53
`define ICW_W_SUP2        8'h54
`define ICW_W_EN0         8'h55
`define ICW_W_EN1         8'h56
`define ICW_W_EN2         8'h57
`define ICW_W_ULTRA_DMA        8'h58
`define ICW_W_PWR         8'hA0
`define ICW_W_ADV         8'hA3
`define ICW_W_CBUS        8'hA4

// ---------------------------------------------------------------------------
// Fixed bit patterns
// ---------------------------------------------------------------------------
`define ICW_FEAT0_FIXED   16'h7008
`define ICW_FEAT1_FLASH   16'h4004
`define ICW_VALID_TAG     16'h4000
`define ICW_XLAT_VALUE    16'h0007
`define ICW_CURRENT_MASK  16'h0FFF

// ---------------------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------------------
`define ICW_CFG_RST       32'h0000_0000
`define ICW_CUR_RST       12'h064
`define ICW_CODE_RSV      3'h7
`define ICW_ULTRA_DMA_MAX      3'h6
`define ICW_ADV_MAX       3'h2
`define ICW_CB_MAX        3'h3

`endif

// ### rtl/icw_pkg.sv
/*
  Types shared by the identify capability word block.
  Assumes the constants header is on the include path.
*/
package icw_pkg;
  `include "icw_params.svh"

  typedef enum logic [1:0] {
    ICW_DMA_NONE  = 2'b00,
    ICW_DMA_MWORD = 2'b01,
    ICW_DMA_ULTRA = 2'b10
  } icw_dma_kind_t;

  typedef struct packed {
    logic [15:0]   pwr_cfg;
    logic [7:0]    sup_cfg;
    logic [2:0]    ultra_dma_sup;
    logic          disk_emulation_mode;
    icw_dma_kind_t dma_kind;
    logic [2:0]    ultra_dma_sel;
    logic [2:0]    adv_pio_sel;
    logic [2:0]    adv_mdma_sel;
    logic [2:0]    cb_ultra_dma_sel;
    logic [4:0]    feat_en;
    logic [17:0]   timing_cap;
    logic [7:0]    word_index;
    logic [15:0]   word_data;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          nv_store;
  } icw_state_t;
endpackage

// ### tb/icw_words_monitor.sv
/* Checker for the identify word block: APB answers and word fields.
   Assumes it is bound onto icw_words and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module icw_words_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        nv_health_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [15:0] ident_word_o,
  input wire logic        nv_store_o
);
  // ---------------------------------------------------------------------
  // Index tracking
  // ---------------------------------------------------------------------
  // Words settle a cycle after a write, so checks wait three quiet edges.
  logic [7:0] idx_reg;
  logic [1:0] age_reg;
  logic       wdone;
  logic       fw;
  logic       ok;
  assign wdone = psel_i && penable_i && pready_o && pwrite_i;
  assign fw    = wdone && paddr_i == 12'h008;
  assign ok    = age_reg == 2'h3;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      idx_reg <= 8'h00;
      age_reg <= 2'h0;
    end else begin
      if (wdone && paddr_i == 12'h010) begin
        idx_reg <= pwdata_i[7:0];
      end
      age_reg <= wdone ? 2'h0 : (ok ? 2'h3 : age_reg + 2'h1);
    end
  end
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wait; psel_i && penable_i && !pready_o; endsequence
  sequence s_done; psel_i && penable_i && pready_o; endsequence
  property p_answer; s_wait |=> pready_o; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_err;
    s_done ##0 paddr_i > 12'h018 |-> pslverr_o && (pwrite_i || !prdata_o);
  endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_nv; nv_store_o |-> fw; endproperty
  a_nv: assert property (p_nv) else $error("stray store");
  property p_tag;
    ok && (idx_reg == 8'h53 || idx_reg == 8'h54) |->
      ident_word_o[15:14] == 2'b01;
  endproperty
  a_tag: assert property (p_tag) else $error("tag bits");
  property p_sup0;
    ok && idx_reg == 8'h52 |-> (ident_word_o & 16'h779C) == 16'h7008;
  endproperty
  a_sup0: assert property (p_sup0) else $error("word 82");
  property p_en0;
    ok && idx_reg == 8'h55 |-> (ident_word_o & 16'h779C) == 16'h7008;
  endproperty
  a_en0: assert property (p_en0) else $error("word 85");
  property p_sup1;
    ok && idx_reg == 8'h53 |-> (ident_word_o & 16'h0017) == 16'h0004;
  endproperty
  a_sup1: assert property (p_sup1) else $error("word 83");
  property p_en1;
    ok && idx_reg == 8'h56 |-> (ident_word_o & 16'h0013) == 16'h0000;
  endproperty
  a_en1: assert property (p_en1) else $error("word 86");
  property p_en2; ok && idx_reg == 8'h57 |-> ident_word_o == 16'h4000;
  endproperty
  a_en2: assert property (p_en2) else $error("word 87");
  property p_sel;
    ok && idx_reg == 8'h58 |-> $onehot0(ident_word_o[14:8]) &&
      !ident_word_o[15] && !ident_word_o[7];
  endproperty
  a_sel: assert property (p_sel) else $error("word 88 select");
  property p_cum;
    ok && idx_reg == 8'h58 |->
      ((ident_word_o[6:0] + 7'h01) & ident_word_o[6:0]) == 7'h00;
  endproperty
  a_cum: assert property (p_cum) else $error("word 88 support");
  property p_pwr; ok && idx_reg == 8'hA0 |-> !ident_word_o[14];
  endproperty
  a_pwr: assert property (p_pwr) else $error("word 160");
  property p_xlat; ok && idx_reg == 8'h35 |-> ident_word_o[2];
  endproperty
  a_xlat: assert property (p_xlat) else $error("word 53");
endmodule // icw_words_monitor
bind icw_words icw_words_monitor mon_u (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .nv_health_i(nv_health_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ident_word_o(ident_word_o), .nv_store_o(nv_store_o));
`default_nettype wire

// ### tb/icw_host_model.sv
/* Host model: APB master for identification reads, plus the storage cell
   that keeps the health enable. Assumes one clock shared with the block. */
`timescale 1ns/1ps
`default_nettype none
module icw_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic        nv_store_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o,
  output logic             nv_health_o
);
  logic feat_bit;
  initial begin
    psel_o      = 1'b0;
    penable_o   = 1'b0;
    pwrite_o    = 1'b0;
    paddr_o     = 12'h000;
    pwdata_o    = 32'h0;
    pstrb_o     = 4'hF;
    nv_health_o = 1'b1;
    feat_bit    = 1'b1;
  end
  // The cell survives a block reset, as a power cycle would leave it.
  always @(posedge clk_sys_i) begin
    if (nv_store_i === 1'b1) begin
      nv_health_o <= feat_bit;
    end
  end
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    // The cell value is ready before the store pulse can arrive.
    if (wr && a == 12'h008) begin
      feat_bit = d[0];
    end
    @(posedge clk_sys_i);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    do @(posedge clk_sys_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule // icw_host_model
`default_nettype wire

// ### tb/identify_capability_words_bench.sv
/* Self-checking bench for the identify word block.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module identify_capability_words_bench;
  logic        clk_sys_i;
  logic        rstn_i = 1'b0;
  logic        nv_health, psel, penable, pwrite, pready, pslverr, nv_store;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [15:0] ident_word_o;
  int          num_errors = 0;
  int          checks = 0;
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  icw_words dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .nv_health_i(nv_health), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ident_word_o(ident_word_o),
    .nv_store_o(nv_store));
  icw_host_model host_u (.clk_sys_i(clk_sys_i), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr), .nv_store_i(nv_store),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .nv_health_o(nv_health));
  // -----------------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b1, a, d, q, e);
  endtask
  task automatic chk(input logic [7:0] i, input logic [15:0] x);
    logic [31:0] q;
    logic        e;
    wr(12'h010, {24'h0, i});
    host_u.xfer(1'b0, 12'h014, 32'h0, q, e);
    cmp("data", {16'h0, x}, q);
    cmp("ident", {16'h0, x}, {16'h0, ident_word_o});
  endtask
  // Boot done must show before the stored health enable is trusted.
  task automatic reset_dut(output logic [31:0] q);
    logic e;
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    q = 32'h0;
    while (q[2] !== 1'b1) host_u.xfer(1'b0, 12'h018, 32'h0, q, e);
    host_u.xfer(1'b0, 12'h008, 32'h0, q, e);
  endtask
  task tally_and_finish;
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // -----------------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        e;
    reset_dut(q);
    cmp("feat", 32'h1, q);
    host_u.xfer(1'b0, 12'h000, 32'h0, q, e);
    cmp("cfg", 32'h8064_0000, q);
    wr(12'h000, 32'hF1F4_181F);
    wr(12'h004, 32'h0000_001A);
    wr(12'h008, 32'h0000_001E);
    chk(8'h52, 16'h706B);
    chk(8'h53, 16'h400C);
    chk(8'h54, 16'h4000);
    chk(8'h55, 16'h706A);
    chk(8'h56, 16'h000C);
    chk(8'h57, 16'h4000);
    chk(8'h58, 16'h081F);
    chk(8'hA0, 16'hB1F4);
    chk(8'h35, 16'h0007);
    wr(12'h00C, 32'h0002_58D1);
    wr(12'h004, 32'h0000_6281);
    chk(8'hA3, 16'h0291);
    chk(8'h58, 16'h001F);
    wr(12'h004, 32'h0000_6282);
    chk(8'hA4, 16'hE959);
    chk(8'h58, 16'h011F);
    wr(12'h000, 32'hF1F4_081F);
    chk(8'h58, 16'h0000);
    host_u.xfer(1'b0, 12'h01C, 32'h0, q, e);
    cmp("slverr", 32'h1, {31'h0, e});
    cmp("rdata", 32'h0, q);
    reset_dut(q);
    cmp("feat", 32'h0, q);
    tally_and_finish();
  end
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    num_errors++;
    tally_and_finish();
  end
endmodule // identify_capability_words_bench
`default_nettype wire
